// file: inc/sclkrt_pkg.sv
// Constants and types for the slow clock and reset timing block
package sclkrt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] CTRL_IDX   = 10'h098;
    localparam logic [9:0] RSTDLY_IDX = 10'h099;
    localparam logic [9:0] WAIT_IDX   = 10'h097;
    localparam logic [9:0] STAT_IDX   = 10'h09F;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] RSTDLY_RST = 8'h00;
    localparam logic [7:0] WAIT_RST   = 8'h00;
    // Slow clock control fields
    localparam int OUT_EN_BIT   = 7;
    localparam int CAL_GATE_BIT = 6;
    localparam int OUT_GATE_BIT = 5;
    localparam int TRIG_SEL_BIT = 4;
    localparam int CRYSTAL_BIT  = 3;
    // Sequencer wait fields
    localparam int TIMEOUT_BIT = 5;
    localparam int TMODE_BIT   = 4;
    // Reset hold trigger codes
    localparam logic [1:0] EV_EXT_WAKE = 2'h0;
    localparam logic [1:0] EV_SYSTEM_UP_EVENT   = 2'h1;
    localparam logic [1:0] EV_POWER_UP_EVENT   = 2'h2;
    localparam logic [1:0] EV_LEAVE    = 2'h3;
    localparam logic [5:0] RST_LIN_TOP = 6'h20;
    localparam logic [5:0] RST_BASE    = 6'h1F;
    // Times, counted in 32 kHz ticks
    localparam int TICK_HZ         = 32768;
    localparam int WAIT_UNIT_US    = 512;
    localparam int RST_UNIT_US     = 1024;
    localparam int SETTLE_STEP_MS  = 520;
    localparam int WAIT_TIMEOUT_MS = 500;
    localparam int WAIT_UNIT_TICKS = WAIT_UNIT_US * TICK_HZ / 1000000;
    localparam int RST_UNIT_TICKS  = RST_UNIT_US * TICK_HZ / 1000000;
    localparam int SETTLE_TICKS    = SETTLE_STEP_MS * TICK_HZ / 1000;
    localparam int TIMEOUT_TICKS   = WAIT_TIMEOUT_MS * TICK_HZ / 1000;
    localparam int RST_LIN_STEPS   = 32;
    // Duty window limits in percent
    localparam logic [15:0] DUTY_LO_PCT = 16'h001E;
    localparam logic [15:0] DUTY_HI_PCT = 16'h0046;
    localparam logic [15:0] PCT_FULL    = 16'h0064;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {W_IDLE, W_TIMER, W_PIN} sclkrt_wait_t;
endpackage

// file: verilog/sclkrt_top.sv
// Slow clock gating, settle timer, sequencer wait and reset hold timer
// Operation
// - Wait code 0 is no delay; code n waits 512 us times 2^(n-1).
// - Control bit 7 switches the slow clock output buffer on or off.
// - With a slow clock slot, output enables when the sequencer reaches it.
// - With pause flag and pause slot, enable waits for that slot going up.
// - With output gating set, enable waits until the oscillator is stable.
// - Bit 6 set blocks the calendar clock until the settle timer expires.
// - Bit 5 set blocks output and shared clock pins until settle expiry.
// - Trigger select clear: settle timer starts when duty is 30..70 %.
// - Trigger select set: crystal rise, calendar change, or ship exit with bit 3 set.
// - Bit 3 tells whether a crystal is fitted or a clock is bypassed.
// - Settle code 0 disables the delay; each step adds about 0.52 s.
// - Reset trigger: 0 wakeup, 1 system up, 2 power up, 3 leave reset.
// - Reset codes up to 32 give code times 1.024 ms.
// - Reset codes above 32 step by 32.768 ms up to 1048.576 ms.
// - Timer mode waits the selected delay at the wait slot.
// - Wait direction: none, power-up, power-down or both.
// - Pin wait gives up after 500 ms when timeout is set.
// - Slow clock slot sets where the outputs enable or disable.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sclkrt_top #(
    parameter int SETTLE_STEP = sclkrt_pkg::SETTLE_TICKS,
    parameter int TIMEOUT_LEN = sclkrt_pkg::TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // AXI4-Lite slave
    input  wire logic [11:0] AWADDR,
    input  wire logic        AWVALID,
    output var  logic        AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output var  logic        WREADY,
    output var  logic [1:0]  BRESP,
    output var  logic        BVALID,
    input  wire logic        BREADY,
    input  wire logic [11:0] ARADDR,
    input  wire logic        ARVALID,
    output var  logic        ARREADY,
    output var  logic [31:0] RDATA,
    output var  logic [1:0]  RRESP,
    output var  logic        RVALID,
    input  wire logic        RREADY,
    // Pins
    input  wire logic        OSC_32K,
    input  wire logic        WAIT_INPUT_PIN,
    // Sequencer
    input  wire logic        SLOT_REACHED,
    input  wire logic [3:0]  SEQ_SLOT,
    input  wire logic        SEQ_POWER_DOWN,
    input  wire logic [3:0]  SLOW_CLOCK_SLOT,
    input  wire logic [3:0]  PAUSE_SLOT,
    input  wire logic        SLOW_CLOCK_PAUSE_FLAG,
    input  wire logic [3:0]  WAIT_SLOT,
    input  wire logic        CAL_ENABLE,
    input  wire logic        LEAVE_SHIP_STATE,
    input  wire logic        EXTERNAL_WAKEUP_EVENT,
    input  wire logic        SYSTEM_UP_EVENT,
    input  wire logic        POWER_UP_EVENT,
    input  wire logic        LEAVE_RESET_EVENT,
    // Outputs
    output var  logic        SLOW_CLOCK_OUT_EN,
    output var  logic        SHARED_CLOCK_EN,
    output var  logic        CAL_CLOCK_EN,
    output var  logic        CRYSTAL_FITTED,
    output var  logic        RESET_HOLD,
    output var  logic        WAIT_DONE
);
    // Decoded select: ctrl, reset delay, wait, status
    function automatic logic [3:0] reg_sel(input logic [11:0] a);
        logic [9:0] i;
        i = a[11:2];
        reg_sel = 4'h0;
        if (a[1:0] == 2'h0) begin
            reg_sel = {i == sclkrt_pkg::STAT_IDX,
                       i == sclkrt_pkg::WAIT_IDX,
                       i == sclkrt_pkg::RSTDLY_IDX,
                       i == sclkrt_pkg::CTRL_IDX};
        end
    endfunction

    logic [7:0]  ctrl, rstdly, waitc, status;
    logic [7:0]  next_ctrl, next_rstdly, next_waitc;
    logic        aw_held, w_held, next_aw_held, next_w_held;
    logic [11:0] aw_addr, next_aw_addr;
    logic [7:0]  w_byte, next_w_byte;
    logic        w_lane, next_w_lane;
    logic        next_awready, next_wready, next_bvalid, next_arready;
    logic        next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [3:0]  wsel, rsel;
    logic        xtal_rise;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_ctrl = ctrl;
        next_rstdly = rstdly;
        next_waitc = waitc;
        next_bvalid = BVALID & ~BREADY;
        next_bresp = BRESP;
        next_rvalid = RVALID & ~RREADY;
        next_rdata = RDATA;
        next_rresp = RRESP;
        wsel = reg_sel(aw_addr);
        rsel = reg_sel(ARADDR);
        if (AWVALID && AWREADY) begin
            next_aw_held = 1'b1;
            next_aw_addr = AWADDR;
        end
        if (WVALID && WREADY) begin
            next_w_held = 1'b1;
            next_w_byte = WDATA[7:0];
            next_w_lane = WSTRB[0];
        end
        if (aw_held && w_held && !BVALID) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wsel[2:0] != 3'h0) ? sclkrt_pkg::RESP_OKAY
                                             : sclkrt_pkg::RESP_SLVERR;
            if (w_lane && wsel[0]) next_ctrl = w_byte;
            if (w_lane && wsel[1]) next_rstdly = w_byte;
            if (w_lane && wsel[2]) next_waitc = w_byte;
        end
        if (ARVALID && ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp = (rsel != 4'h0) ? sclkrt_pkg::RESP_OKAY
                                        : sclkrt_pkg::RESP_SLVERR;
            next_rdata = 32'h0;
            if (rsel[0]) next_rdata[7:0] = ctrl;
            if (rsel[1]) next_rdata[7:0] = rstdly;
            if (rsel[2]) next_rdata[7:0] = waitc;
            if (rsel[3]) next_rdata[7:0] = status;
        end
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready = ~next_w_held & ~next_bvalid;
        next_arready = ~next_rvalid;
        xtal_rise = next_ctrl[sclkrt_pkg::CRYSTAL_BIT]
                    & ~ctrl[sclkrt_pkg::CRYSTAL_BIT];
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            ctrl <= sclkrt_pkg::CTRL_RST;
            rstdly <= sclkrt_pkg::RSTDLY_RST;
            waitc <= sclkrt_pkg::WAIT_RST;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= 2'h0;
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            ctrl <= next_ctrl;
            rstdly <= next_rstdly;
            waitc <= next_waitc;
            AWREADY <= next_awready;
            WREADY <= next_wready;
            BVALID <= next_bvalid;
            BRESP <= next_bresp;
            ARREADY <= next_arready;
            RVALID <= next_rvalid;
            RDATA <= next_rdata;
            RRESP <= next_rresp;
        end
    end

    // Pin synchronisers; stage one feeds stage two only
    logic [1:0] sync1, sync2;
    logic       osc_prev, tick;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            osc_prev <= 1'b0;
        end else begin
            sync1 <= {WAIT_INPUT_PIN, OSC_32K};
            sync2 <= sync1;
            osc_prev <= sync2[0];
        end
    end
    assign tick = sync2[0] & ~osc_prev;

    // Timers stepped by the oscillator's own rising edges; duty counters step every CLK
    logic [15:0] hi_cnt, per_cnt, next_hi_cnt, next_per_cnt;
    logic        duty_ok, next_duty_ok, cal_prev;
    logic [19:0] st_cnt, rs_cnt, wt_cnt, next_st_cnt, next_rs_cnt;
    logic [19:0] next_wt_cnt, st_len, rs_len, wt_len;
    logic        stable, st_run, next_stable, next_st_run;
    logic        next_rst_hold, next_wait_done;
    logic        st_trig, st_abort, rs_trig, wait_hit, wait_apply;
    sclkrt_pkg::sclkrt_wait_t wstate, next_wstate;

    always_comb begin
        next_hi_cnt = hi_cnt;
        next_per_cnt = per_cnt;
        next_duty_ok = duty_ok;
        if (tick) begin
            // Widened: a full 16-bit count times 100 would wrap
            next_duty_ok = (24'(hi_cnt) * 24'(sclkrt_pkg::PCT_FULL)
                            >= 24'(per_cnt)
                               * 24'(sclkrt_pkg::DUTY_LO_PCT))
                        && (24'(hi_cnt) * 24'(sclkrt_pkg::PCT_FULL)
                            <= 24'(per_cnt)
                               * 24'(sclkrt_pkg::DUTY_HI_PCT));
            next_hi_cnt = 16'h0;
            next_per_cnt = 16'h0;
        end else if (per_cnt != 16'hFFFF) begin
            next_per_cnt = per_cnt + 16'h1;
            next_hi_cnt = hi_cnt + {15'h0, sync2[0]};
        end else begin
            next_duty_ok = 1'b0;
        end
        st_len = 20'(ctrl[2:0]) * 20'(SETTLE_STEP);
        if (ctrl[sclkrt_pkg::TRIG_SEL_BIT]) begin
            st_trig = xtal_rise | (CAL_ENABLE ^ cal_prev)
                    | (LEAVE_SHIP_STATE
                       & ctrl[sclkrt_pkg::CRYSTAL_BIT]);
            st_abort = 1'b0;
        end else begin
            st_trig = next_duty_ok & ~duty_ok;
            st_abort = ~duty_ok;
        end
        next_st_cnt = st_cnt;
        next_st_run = st_run;
        next_stable = stable;
        if (st_trig) begin
            next_st_cnt = 20'h0;
            next_st_run = (st_len != 20'h0);
            next_stable = (st_len == 20'h0);
        end else if (st_abort) begin
            next_st_run = 1'b0;
            next_stable = 1'b0;
        end else if (st_run && tick) begin
            next_st_cnt = st_cnt + 20'h1;
            if (next_st_cnt >= st_len) begin
                next_st_run = 1'b0;
                next_stable = 1'b1;
            end
        end
        case (rstdly[7:6])
            sclkrt_pkg::EV_EXT_WAKE: rs_trig = EXTERNAL_WAKEUP_EVENT;
            sclkrt_pkg::EV_SYSTEM_UP_EVENT:   rs_trig = SYSTEM_UP_EVENT;
            sclkrt_pkg::EV_POWER_UP_EVENT:   rs_trig = POWER_UP_EVENT;
            default:                 rs_trig = LEAVE_RESET_EVENT;
        endcase
        if (rstdly[5:0] <= sclkrt_pkg::RST_LIN_TOP) begin
            rs_len = 20'(rstdly[5:0])
                   * 20'(sclkrt_pkg::RST_UNIT_TICKS);
        end else begin
            rs_len = 20'(rstdly[5:0] - sclkrt_pkg::RST_BASE)
                   * 20'(sclkrt_pkg::RST_LIN_STEPS
                         * sclkrt_pkg::RST_UNIT_TICKS);
        end
        next_rs_cnt = rs_cnt;
        next_rst_hold = RESET_HOLD;
        if (rs_trig) begin
            next_rs_cnt = 20'h0;
            next_rst_hold = (rs_len != 20'h0);
        end else if (RESET_HOLD && tick) begin
            next_rs_cnt = rs_cnt + 20'h1;
            if (next_rs_cnt >= rs_len) next_rst_hold = 1'b0;
        end
        wt_len = (waitc[3:0] == 4'h0) ? 20'h0
               : 20'(sclkrt_pkg::WAIT_UNIT_TICKS)
                 << (waitc[3:0] - 4'h1);
        wait_hit = SLOT_REACHED && (SEQ_SLOT == WAIT_SLOT);
        wait_apply = SEQ_POWER_DOWN ? waitc[7] : waitc[6];
        next_wstate = wstate;
        next_wt_cnt = wt_cnt;
        next_wait_done = 1'b0;
        case (wstate)
            sclkrt_pkg::W_IDLE: begin
                next_wt_cnt = 20'h0;
                if (wait_hit) begin
                    if (!wait_apply) begin
                        next_wait_done = 1'b1;
                    end else if (waitc[sclkrt_pkg::TMODE_BIT]) begin
                        if (wt_len == 20'h0) next_wait_done = 1'b1;
                        else next_wstate = sclkrt_pkg::W_TIMER;
                    end else begin
                        next_wstate = sclkrt_pkg::W_PIN;
                    end
                end
            end
            sclkrt_pkg::W_TIMER: begin
                if (tick) next_wt_cnt = wt_cnt + 20'h1;
                if (next_wt_cnt >= wt_len) begin
                    next_wait_done = 1'b1;
                    next_wstate = sclkrt_pkg::W_IDLE;
                end
            end
            sclkrt_pkg::W_PIN: begin
                if (tick && waitc[sclkrt_pkg::TIMEOUT_BIT]) begin
                    next_wt_cnt = wt_cnt + 20'h1;
                end
                if (sync2[1] || next_wt_cnt >= 20'(TIMEOUT_LEN)) begin
                    next_wait_done = 1'b1;
                    next_wstate = sclkrt_pkg::W_IDLE;
                end
            end
            default: next_wstate = sclkrt_pkg::W_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            hi_cnt <= 16'h0;
            per_cnt <= 16'h0;
            duty_ok <= 1'b0;
            cal_prev <= 1'b0;
            st_cnt <= 20'h0;
            st_run <= 1'b0;
            stable <= 1'b0;
            rs_cnt <= 20'h0;
            RESET_HOLD <= 1'b0;
            wt_cnt <= 20'h0;
            wstate <= sclkrt_pkg::W_IDLE;
            WAIT_DONE <= 1'b0;
        end else begin
            hi_cnt <= next_hi_cnt;
            per_cnt <= next_per_cnt;
            duty_ok <= next_duty_ok;
            cal_prev <= CAL_ENABLE;
            st_cnt <= next_st_cnt;
            st_run <= next_st_run;
            stable <= next_stable;
            rs_cnt <= next_rs_cnt;
            RESET_HOLD <= next_rst_hold;
            wt_cnt <= next_wt_cnt;
            wstate <= next_wstate;
            WAIT_DONE <= next_wait_done;
        end
    end

    // Clock enables; sequence gate is dropped again going down
    logic       seq_ok, next_seq_ok, next_out_en, next_shared, next_cal;
    logic [3:0] target;
    always_comb begin
        target = (SLOW_CLOCK_PAUSE_FLAG && PAUSE_SLOT != 4'h0)
               ? PAUSE_SLOT : SLOW_CLOCK_SLOT;
        next_seq_ok = seq_ok;
        if (!ctrl[sclkrt_pkg::OUT_EN_BIT]) begin
            next_seq_ok = 1'b0;
        end else if (target == 4'h0) begin
            next_seq_ok = 1'b1;
        end else if (SLOT_REACHED && !SEQ_POWER_DOWN
                     && SEQ_SLOT == target) begin
            next_seq_ok = 1'b1;
        end else if (SLOT_REACHED && SEQ_POWER_DOWN
                     && SEQ_SLOT == SLOW_CLOCK_SLOT) begin
            next_seq_ok = 1'b0;
        end
        next_shared = ~ctrl[sclkrt_pkg::OUT_GATE_BIT] | stable;
        next_cal = ~ctrl[sclkrt_pkg::CAL_GATE_BIT] | stable;
        next_out_en = ctrl[sclkrt_pkg::OUT_EN_BIT] & next_seq_ok
                    & next_shared;
        status = {3'h0, seq_ok, duty_ok, wstate != sclkrt_pkg::W_IDLE,
                  RESET_HOLD, stable};
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            seq_ok <= 1'b0;
            SLOW_CLOCK_OUT_EN <= 1'b0;
            SHARED_CLOCK_EN <= 1'b0;
            CAL_CLOCK_EN <= 1'b0;
            CRYSTAL_FITTED <= 1'b0;
        end else begin
            seq_ok <= next_seq_ok;
            SLOW_CLOCK_OUT_EN <= next_out_en;
            SHARED_CLOCK_EN <= next_shared;
            CAL_CLOCK_EN <= next_cal;
            CRYSTAL_FITTED <= ctrl[sclkrt_pkg::CRYSTAL_BIT];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_out_off;
        !ctrl[sclkrt_pkg::OUT_EN_BIT] |=> !SLOW_CLOCK_OUT_EN;
    endproperty
    a_out_off: assert property (p_out_off) else $error("out on");
    property p_gate_wait;
        ctrl[sclkrt_pkg::OUT_GATE_BIT] && !stable |=> !SLOW_CLOCK_OUT_EN
            && !SHARED_CLOCK_EN;
    endproperty
    a_gate_wait: assert property (p_gate_wait)
        else $error("gated");
    property p_cal_free;
        !ctrl[sclkrt_pkg::CAL_GATE_BIT] |=> CAL_CLOCK_EN;
    endproperty
    a_cal_free: assert property (p_cal_free) else $error("cal");
    property p_cal_gate;
        ctrl[sclkrt_pkg::CAL_GATE_BIT] && !stable |=> !CAL_CLOCK_EN;
    endproperty
    a_cal_gate: assert property (p_cal_gate) else $error("calg");
    property p_restart;
        st_trig && st_len != 20'h0 |=> !stable && st_cnt == 20'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("rst");
    property p_hold;
        rs_trig && rs_len != 20'h0 |=> RESET_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_nowait;
        wstate == sclkrt_pkg::W_IDLE && wait_hit && !wait_apply
            |=> WAIT_DONE;
    endproperty
    a_nowait: assert property (p_nowait) else $error("dir");
    property p_pin;
        wstate == sclkrt_pkg::W_PIN && sync2[1] |=> WAIT_DONE
            ##1 !WAIT_DONE;
    endproperty
    a_pin: assert property (p_pin) else $error("pin");
    property p_seq;
        ctrl[sclkrt_pkg::OUT_EN_BIT] && !seq_ok && target != 4'h0
            && !SLOT_REACHED |=> !SLOW_CLOCK_OUT_EN;
    endproperty
    a_seq: assert property (p_seq) else $error("seq");
    c_stable: cover property ($rose(stable));
    c_hold: cover property ($fell(RESET_HOLD));
    c_wait: cover property (wstate == sclkrt_pkg::W_TIMER ##1 WAIT_DONE);
endmodule
`default_nettype wire

// file: verification/test_sclkrt_top.sv
// Self-checking bench for the slow clock and reset timing block
`timescale 1ns/1ps
`default_nettype none
module test_sclkrt_top;
    logic        CLK = 0, RESET = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic        ARVALID = 0, RREADY = 0, OSC_32K = 0, WAIT_INPUT_PIN = 0;
    logic        SLOT_REACHED = 0, SEQ_POWER_DOWN = 0, CAL_ENABLE = 0;
    logic        SLOW_CLOCK_PAUSE_FLAG = 0, LEAVE_SHIP_STATE = 0;
    logic [11:0] AWADDR = 0, ARADDR = 0, a;
    logic [31:0] WDATA = 0, rnd = 32'h00011F8B;
    logic [3:0]  WSTRB = 4'hF, SEQ_SLOT = 0, SLOW_CLOCK_SLOT = 0;
    logic [3:0]  PAUSE_SLOT = 0, WAIT_SLOT = 4'h3, ev = 0;
    logic [2:0]  ph = 0, hi = 0;
    logic [5:0]  c6;
    logic [7:0]  wv [7] = '{8'h51, 8'h53, 8'h51, 8'hD2, 8'h40, 8'h60, 8'h50};
    int          we [7] = '{128, 512, 1, 256, 3, 64, 1};
    int          fails = 0, num_checks = 0, c;
    wire logic   AWREADY, WREADY, BVALID, ARREADY, RVALID, WAIT_DONE;
    wire logic   SLOW_CLOCK_OUT_EN, SHARED_CLOCK_EN, CAL_CLOCK_EN;
    wire logic   CRYSTAL_FITTED, RESET_HOLD;
    wire logic [1:0]  BRESP, RRESP;
    wire logic [31:0] RDATA;
    localparam logic [11:0] A_WAIT = {sclkrt_pkg::WAIT_IDX, 2'b00};
    localparam logic [11:0] A_CTRL = {sclkrt_pkg::CTRL_IDX, 2'b00};
    localparam logic [11:0] A_RST  = {sclkrt_pkg::RSTDLY_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {sclkrt_pkg::STAT_IDX, 2'b00};

    sclkrt_top #(.SETTLE_STEP(4), .TIMEOUT_LEN(8)) i_dut (.*,
        .EXTERNAL_WAKEUP_EVENT(ev[0]), .SYSTEM_UP_EVENT(ev[1]),
        .POWER_UP_EVENT(ev[2]), .LEAVE_RESET_EVENT(ev[3]));

    always #12.5 CLK = ~CLK;
    // Oscillator period of 8 clocks keeps tick spacing exact
    always @(posedge CLK) begin
        ph <= ph + 3'h1;
        OSC_32K <= (ph < hi);
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int rst_ticks(input logic [5:0] k);
        return (k <= 6'h20) ? k * 33 : (k - 31) * 32 * 33;
    endfunction
    function automatic logic pick(input int w);
        case (w)
            0: return WAIT_DONE;
            1: return RESET_HOLD;
            2: return SLOW_CLOCK_OUT_EN;
            default: return CAL_CLOCK_EN;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, input int g);
        num_checks++;
        if (g < e - 16 || g > e + 16) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic count(input int w, input logic v, output int k);
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (pick(w) !== v && k < 20000);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge CLK);
        AWADDR <= ad;
        WDATA <= d;
        AWVALID <= 1;
        WVALID <= 1;
        BREADY <= 1;
        do begin
            @(posedge CLK);
            n++;
            if (AWREADY === 1'b1) AWVALID <= 0;
            if (WREADY === 1'b1) WVALID <= 0;
        end while (BVALID !== 1'b1 && n < 99);
        BREADY <= 0;
        chk("bvalid", 1, BVALID);
        chk("bresp", er, BRESP);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge CLK);
        ARADDR <= ad;
        ARVALID <= 1;
        RREADY <= 1;
        do begin
            @(posedge CLK);
            n++;
            if (ARREADY === 1'b1) ARVALID <= 0;
        end while (RVALID !== 1'b1 && n < 99);
        RREADY <= 0;
        chk("rvalid", 1, RVALID);
        chk("rdata", e, RDATA);
        chk("rresp", er, RRESP);
    endtask
    // Pulse leaves one edge for the registered response to land
    task automatic fire(input logic [3:0] m);
        @(posedge CLK);
        ev <= m;
        @(posedge CLK);
        ev <= 0;
        @(posedge CLK);
    endtask
    task automatic slot(input logic [3:0] s, input int w);
        @(posedge CLK);
        SEQ_SLOT <= s;
        SLOT_REACHED <= 1;
        @(posedge CLK);
        SLOT_REACHED <= 0;
        repeat (w) @(posedge CLK);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge CLK);
        fails++;
        results();
    end

    initial begin
        repeat (2) @(posedge CLK);
        RESET <= 0;
        rd(12'h100, 0, 2);
        wr(A_STAT, 8'hFF, 2);
        for (int i = 0; i < 3; i++) begin
            a = A_WAIT + 12'(4 * i);
            rnd = lfsr(rnd);
            rd(a, 0, 0);
            wr(a, rnd[7:0], 0);
            WSTRB <= 0;
            wr(a, ~rnd, 0);
            WSTRB <= 4'hF;
            rd(a, rnd[7:0], 0);
            wr(a, 0, 0);
        end
        $display("registers done");
        hi <= 4;
        for (int t = 0; t < 4; t++) begin
            rnd = lfsr(rnd);
            c6 = (t == 3) ? 6'h21 : 6'(1 + rnd % 3);
            wr(A_RST, {t[1:0], c6}, 0);
            fire(4'h1 << ((t + 1) % 4));
            chk("hold_other", 0, RESET_HOLD);
            fire(4'h1 << t);
            chk("hold_start", 1, RESET_HOLD);
            count(1, 0, c);
            near("hold_len", rst_ticks(c6) * 8, c);
        end
        $display("reset hold done");
        hi <= 1;
        wr(A_CTRL, 8'hE2, 0);
        repeat (40) @(posedge CLK);
        chk("out_en", 0, SLOW_CLOCK_OUT_EN);
        chk("cal_en", 0, CAL_CLOCK_EN);
        chk("shared_en", 0, SHARED_CLOCK_EN);
        hi <= 4;
        count(2, 1, c);
        // Up to two oscillator periods pass before the duty is judged
        near("settle", 72, c);
        chk("cal_en", 1, CAL_CLOCK_EN);
        chk("shared_en", 1, SHARED_CLOCK_EN);
        rd(A_STAT, 32'h19, 0);
        hi <= 1;
        repeat (40) @(posedge CLK);
        chk("out_abort", 0, SLOW_CLOCK_OUT_EN);
        wr(A_CTRL, 8'h8A, 0);
        repeat (2) @(posedge CLK);
        chk("out_nogate", 1, SLOW_CLOCK_OUT_EN);
        chk("cal_nogate", 1, CAL_CLOCK_EN);
        chk("sh_nogate", 1, SHARED_CLOCK_EN);
        chk("crystal", 1, CRYSTAL_FITTED);
        wr(A_CTRL, 8'h0A, 0);
        repeat (2) @(posedge CLK);
        chk("out_off", 0, SLOW_CLOCK_OUT_EN);
        wr(A_CTRL, 8'h52, 0);
        hi <= 4;
        repeat (80) @(posedge CLK);
        chk("cal_mode1", 0, CAL_CLOCK_EN);
        CAL_ENABLE <= 1;
        repeat (40) @(posedge CLK);
        CAL_ENABLE <= 0;
        count(3, 1, c);
        near("restart", 64, c);
        wr(A_CTRL, 8'h5A, 0);
        count(3, 1, c);
        near("xtal", 64, c);
        LEAVE_SHIP_STATE <= 1;
        @(posedge CLK);
        LEAVE_SHIP_STATE <= 0;
        @(posedge CLK);
        count(3, 1, c);
        near("ship", 64, c);
        $display("settle done");
        SLOW_CLOCK_SLOT <= 5;
        PAUSE_SLOT <= 7;
        for (int k = 0; k < 2; k++) begin
            wr(A_CTRL, 8'h00, 0);
            SLOW_CLOCK_PAUSE_FLAG <= k[0];
            wr(A_CTRL, 8'h80, 0);
            chk("pre_slot", 0, SLOW_CLOCK_OUT_EN);
            slot(4'h5, 2);
            chk("at_slot", {31'h0, ~k[0]}, SLOW_CLOCK_OUT_EN);
            slot(4'h7, 2);
            chk("at_pause", 1, SLOW_CLOCK_OUT_EN);
            SEQ_POWER_DOWN <= 1;
            slot(4'h5, 2);
            chk("going_down", 0, SLOW_CLOCK_OUT_EN);
            SEQ_POWER_DOWN <= 0;
        end
        $display("slot gating done");
        rnd = lfsr(rnd);
        wv[1] = 8'h50 | 8'(1 + rnd % 4);
        we[1] = (16 << (wv[1][3:0] - 1)) * 8;
        WAIT_INPUT_PIN <= 1;
        for (int i = 0; i < 7; i++) begin
            wr(A_WAIT, wv[i], 0);
            SEQ_POWER_DOWN <= (i == 2 || i == 3);
            WAIT_INPUT_PIN <= (i == 4);
            slot(4'h3, 0);
            count(0, 1, c);
            near("wait", we[i], c);
        end
        $display("wait done");
        results();
    end
endmodule
`default_nettype wire
